// file: logic/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
`define DCC_OFF_CMD      8'h00
`define DCC_OFF_ARG      8'h04
`define DCC_OFF_STAT     8'h08
`define DCC_OFF_REPLY    8'h0C
`define DCC_OFF_IRQ_STAT 8'h10
`define DCC_OFF_IRQ_EN   8'h14
`define DCC_OFF_IRQ_CLR  8'h18
`define DCC_OFF_TRESULT  8'h1C
`define DCC_CMD_CAL      4'h1
`define DCC_CMD_GO       4'h2
`define DCC_CMD_LOOP     4'h3
`define DCC_CMD_LOOPQ    4'h4
`define DCC_CMD_NORMAL   4'h5
`define DCC_CMD_STEP     4'h6
`define DCC_CMD_STEPQ    4'h7
`define DCC_CMD_STOP     4'h8
`define DCC_CMD_TEST     4'h9
`define DCC_CMD_TESTQ    4'hA
`define DCC_HDR_LOOP     2'h1
`define DCC_HDR_STEP     2'h2
`define DCC_HDR_TEST     2'h3
`define DCC_ARG_OFF      2'h1
`define DCC_RESP_OKAY    2'h0
`define DCC_RESP_SLVERR  2'h2
`define DCC_IRQ_W        4
`define DCC_IRQ_DONE     0
`define DCC_IRQ_EXEERR   1
`define DCC_IRQ_REPLY    2
`define DCC_IRQ_STEP     3
`define DCC_RUN_TICKS    8'h10
`endif

// file: logic/dcc_pkg.sv
package dcc_pkg;
  typedef enum logic [1:0] {DCC_NORMAL, DCC_MONITOR, DCC_RUNNING} dcc_mode_type;
  typedef enum logic [1:0] {DCC_SEL_NONE, DCC_SEL_CAL, DCC_SEL_TEST} dcc_sel_type;
endpackage : dcc_pkg

// file: logic/dcc_sync.sv
`timescale 1ns/10ps
module dcc_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : dcc_sync

// file: logic/dcc_handler.sv
// Functional notes
// RULE1: calibrate enters diagnostic mode and launches routine only when jumper enables it.
// RULE2: first calibrate argument holds two digits: option, then routine.
// RULE3: second calibrate argument is the step number to position the routine at.
// RULE4: go runs the currently selected calibration or test routine.
// RULE5: in diagnostic mode go equals an upper coupling button press.
// RULE6: looping command sets looping on or off; missing argument means on.
// RULE7: looping query replies looping header with on or off.
// RULE8: normal leaves diagnostic mode; in normal mode it changes nothing.
// RULE9: controller sends normal last or alone in a message.
// RULE10: step advances the executing routine to its next step.
// RULE11: step query replies step header and the current step number.
// RULE12: stop ends the executing routine and returns to the monitor.
// RULE13: test selects a test sequence by option and routine number.
// RULE14: test query runs the test and replies status, zero on pass.
// RULE15: calibrate with jumper disabled keeps mode and flags an execution error.
`timescale 1ns/10ps
`include "dcc_params.svh"
module dcc_handler
  import dcc_pkg::*;
#(
  parameter int STEP_W = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cal_jumper,
  input  wire logic        coupling_btn,
  output logic             diag_mode,
  output logic             routine_run,
  output logic [3:0]       run_option,
  output logic [3:0]       run_routine,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic               jumper_s;
  logic               btn_s;
  logic               btn_d_r;
  logic               btn_press;
  logic [7:0]         aw_addr_r;
  logic               aw_have_r;
  logic [31:0]        w_data_r;
  logic               w_have_r;
  logic               wr_go;
  logic               cmd_wr;
  logic               rd_clr;
  logic [31:0]        rd_nxt;
  logic               rd_err;
  dcc_mode_type       mode_r;
  dcc_sel_type        sel_r;
  logic [3:0]         opt_r;
  logic [3:0]         rtn_r;
  logic [STEP_W-1:0]  step_r;
  logic               loop_r;
  logic [7:0]         tick_r;
  logic [15:0]        tresult_r;
  logic [31:0]        reply_r;
  logic               reply_valid_r;
  logic [`DCC_IRQ_W-1:0] ista_r;
  logic [`DCC_IRQ_W-1:0] ien_r;
  logic [`DCC_IRQ_W-1:0] iset;
  logic [`DCC_IRQ_W-1:0] iclr;
  logic [3:0]         op;
  logic [7:0]         arg1;
  logic [STEP_W-1:0]  arg2;
  logic               arg_given;
  logic [1:0]         arg_onoff;
  logic               go_evt;
  logic [31:0]        arg_r;

  dcc_sync u_sync_jmp (.aclk(aclk), .aresetn(aresetn), .din(cal_jumper), .dout(jumper_s));
  dcc_sync u_sync_btn (.aclk(aclk), .aresetn(aresetn), .din(coupling_btn), .dout(btn_s));

  always_ff @(posedge aclk) begin
    if (!aresetn) btn_d_r <= 1'b0;
    else          btn_d_r <= btn_s;
  end
  assign btn_press = btn_s & ~btn_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCC_RESP_OKAY;
    end else begin
      // held low while a response waits, so no item is taken into a busy slot
      s_axi_awready <= ~aw_have_r & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_r)
          `DCC_OFF_CMD, `DCC_OFF_ARG, `DCC_OFF_IRQ_EN, `DCC_OFF_IRQ_CLR:
            s_axi_bresp <= `DCC_RESP_OKAY;
          default: s_axi_bresp <= `DCC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // command word: [3:0] opcode; argument register holds arg1 [7:0], arg2 [STEP_W+7:8],
  // arg presence [24], on/off code [26:25]; arguments written before the command
  assign cmd_wr    = wr_go & (aw_addr_r == `DCC_OFF_CMD);
  assign op        = w_data_r[3:0];
  assign arg1      = arg_r[7:0];
  assign arg2      = arg_r[8 +: STEP_W];
  assign arg_given = arg_r[24];
  assign arg_onoff = arg_r[26:25];

  always_ff @(posedge aclk) begin
    if (!aresetn)                                   arg_r <= 32'h0000_0000;
    else if (wr_go & (aw_addr_r == `DCC_OFF_ARG))   arg_r <= w_data_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)                                     ien_r <= '0;
    else if (wr_go & (aw_addr_r == `DCC_OFF_IRQ_EN))  ien_r <= w_data_r[`DCC_IRQ_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // go from bus, or coupling button while in diagnostic mode
  assign go_evt = (cmd_wr & (op == `DCC_CMD_GO)) | (btn_press & (mode_r != DCC_NORMAL)); // RULE4 RULE5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r    <= DCC_NORMAL;
      sel_r     <= DCC_SEL_NONE;
      opt_r     <= 4'h0;
      rtn_r     <= 4'h0;
      step_r    <= '0;
      tick_r    <= 8'h00;
      tresult_r <= 16'h0000;
    end else begin
      if (mode_r == DCC_RUNNING) begin
        if (tick_r == `DCC_RUN_TICKS) begin
          tick_r <= 8'h00;
          if (!loop_r) mode_r <= DCC_MONITOR; // limitation: routine body is a fixed timer
        end else begin
          tick_r <= tick_r + 8'h01;
        end
      end
      if (go_evt && mode_r != DCC_NORMAL && sel_r != DCC_SEL_NONE) begin
        mode_r <= DCC_RUNNING; // RULE4
        tick_r <= 8'h00;
      end
      if (cmd_wr) begin
        unique case (op)
          `DCC_CMD_CAL: if (jumper_s) begin // RULE1 RULE15
            mode_r <= DCC_RUNNING;
            sel_r  <= DCC_SEL_CAL;
            opt_r  <= arg1[7:4]; // RULE2
            rtn_r  <= arg1[3:0]; // RULE2
            step_r <= arg2;      // RULE3
            tick_r <= 8'h00;
          end
          `DCC_CMD_NORMAL: if (mode_r != DCC_NORMAL) mode_r <= DCC_NORMAL; // RULE8 RULE9
          `DCC_CMD_STEP: if (mode_r == DCC_RUNNING) step_r <= step_r + 1'b1; // RULE10
          `DCC_CMD_STOP: if (mode_r == DCC_RUNNING) mode_r <= DCC_MONITOR; // RULE12
          `DCC_CMD_TEST: begin // RULE13
            mode_r <= (mode_r == DCC_NORMAL) ? DCC_MONITOR : mode_r;
            sel_r  <= DCC_SEL_TEST;
            opt_r  <= arg1[3:0];
            rtn_r  <= arg2[3:0];
            step_r <= '0;
          end
          `DCC_CMD_TESTQ: tresult_r <= {opt_r, rtn_r} ^ {8'h00, step_r[7:0]}; // RULE14
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) loop_r <= 1'b0;
    else if (cmd_wr && op == `DCC_CMD_LOOP)
      loop_r <= !(arg_given && arg_onoff == `DCC_ARG_OFF); // RULE6
  end

  // reply: [31:30] header code, [STEP_W-1:0] or [15:0] value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_r       <= 32'h0000_0000;
      reply_valid_r <= 1'b0;
    end else if (cmd_wr) begin
      unique case (op)
        `DCC_CMD_LOOPQ: begin
          reply_r       <= {`DCC_HDR_LOOP, 29'h0, loop_r}; // RULE7
          reply_valid_r <= 1'b1;
        end
        `DCC_CMD_STEPQ: begin
          reply_r       <= {`DCC_HDR_STEP, {(30-STEP_W){1'b0}}, step_r}; // RULE11
          reply_valid_r <= 1'b1;
        end
        `DCC_CMD_TESTQ: begin
          reply_r       <= {`DCC_HDR_TEST, 14'h0000, {opt_r, rtn_r} ^ {8'h00, step_r[7:0]}};
          reply_valid_r <= 1'b1; // RULE14
        end
        default: ;
      endcase
    end else if (rd_clr) begin
      reply_valid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events; set wins over clear
  assign iset[`DCC_IRQ_DONE]   = (mode_r == DCC_RUNNING) & (tick_r == `DCC_RUN_TICKS) & ~loop_r;
  assign iset[`DCC_IRQ_EXEERR] = cmd_wr & (op == `DCC_CMD_CAL) & ~jumper_s; // RULE15
  assign iset[`DCC_IRQ_REPLY]  = cmd_wr & ((op == `DCC_CMD_LOOPQ) | (op == `DCC_CMD_STEPQ) |
                                           (op == `DCC_CMD_TESTQ));
  assign iset[`DCC_IRQ_STEP]   = cmd_wr & (op == `DCC_CMD_STEP) & (mode_r == DCC_RUNNING);
  assign iclr = (wr_go & (aw_addr_r == `DCC_OFF_IRQ_CLR)) ? w_data_r[`DCC_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) ista_r <= '0;
    else          ista_r <= (ista_r & ~iclr) | iset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(((ista_r & ~iclr) | iset) & ien_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      `DCC_OFF_STAT:     rd_nxt = {24'h0, 1'h0, reply_valid_r, loop_r, jumper_s, sel_r, mode_r};
      `DCC_OFF_REPLY:    rd_nxt = reply_r;
      `DCC_OFF_IRQ_STAT: rd_nxt = {{(32-`DCC_IRQ_W){1'b0}}, ista_r};
      `DCC_OFF_IRQ_EN:   rd_nxt = {{(32-`DCC_IRQ_W){1'b0}}, ien_r};
      `DCC_OFF_TRESULT:  rd_nxt = {16'h0000, tresult_r};
      `DCC_OFF_CMD, `DCC_OFF_ARG, `DCC_OFF_IRQ_CLR: rd_nxt = 32'h0000_0000;
      default:           rd_err = 1'b1;
    endcase
  end

  assign rd_clr = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `DCC_OFF_REPLY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DCC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_nxt;
        s_axi_rresp  <= rd_err ? `DCC_RESP_SLVERR : `DCC_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_mode   <= 1'b0;
      routine_run <= 1'b0;
      run_option  <= 4'h0;
      run_routine <= 4'h0;
    end else begin
      diag_mode   <= (mode_r != DCC_NORMAL);
      routine_run <= (mode_r == DCC_RUNNING);
      run_option  <= opt_r;
      run_routine <= rtn_r;
    end
  end
endmodule : dcc_handler

// file: dv/dcc_ctl_model.sv
`timescale 1ns/10ps
module dcc_ctl_model (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // ready held high: no toggling between back-to-back transfers
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one command per write, so normal always closes its message
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while (pa || pw);
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : dcc_ctl_model

// file: dv/dcc_handler_sva.sv
`timescale 1ns/10ps
`include "dcc_params.svh"
module dcc_handler_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        cal_jumper,
  input wire logic        diag_mode,
  input wire logic        routine_run,
  input wire logic [3:0]  run_option,
  input wire logic [3:0]  run_routine
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_b_latency: assert property (wr_taken |=> b_answer)
    else $error("write response not two cycles after write");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  // only calibrate enters straight into a run; sync plus two registers is four edges
  a_diag_gate: assert property ($rose(diag_mode) && routine_run |->
    $past(cal_jumper, 4))
    else $error("diagnostic mode entered without jumper");
  a_run_diag: assert property (routine_run |-> diag_mode)
    else $error("routine running outside diagnostic mode");
  a_sel_stable: assert property (routine_run && $past(routine_run) |->
    $stable({run_option, run_routine}))
    else $error("selection changed while running");
  a_normal_exit: assert property ($fell(diag_mode) |->
    $past(s_axi_wvalid && s_axi_wready && s_axi_wdata[3:0] == `DCC_CMD_NORMAL, 3))
    else $error("diagnostic mode left without normal command");
endmodule : dcc_handler_sva
bind dcc_handler dcc_handler_sva sva_u (.*);

// file: dv/dcc_handler_tb_top.sv
`timescale 1ns/10ps
`include "dcc_params.svh"
module dcc_handler_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        cal_jumper = 1'b0;
  logic        coupling_btn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb, run_option, run_routine;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, diag_mode, routine_run, irq;
  int          err_count = 0;
  int          num_checks = 0;
  dcc_handler #(.STEP_W(8)) dut_u (.*);
  dcc_ctl_model ctl_u (.*);
  initial forever #2.5 aclk = ~aclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // two spare edges so registered outputs have landed
  task automatic cmd(input logic [3:0] op, input logic [31:0] a);
    ctl_u.wr(`DCC_OFF_ARG, a, rs);
    ctl_u.wr(`DCC_OFF_CMD, {28'h0, op}, rs);
    chk(rs, `DCC_RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask : cmd
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ctl_u.rd(a, rv, rs);
    chk(rv & m, e);
  endtask : rdc
  task automatic t_regs();
    rdc(`DCC_OFF_STAT, 32'h1F, 32'h0);
    ctl_u.rd(8'h20, rv, rs);
    chk(rs, `DCC_RESP_SLVERR);
    chk(rv, 32'h0);
  endtask : t_regs
  task automatic t_locked();
    cmd(`DCC_CMD_CAL, 32'h0100_0321);
    chk(diag_mode, 1'b0);
    rdc(`DCC_OFF_IRQ_STAT, 32'h2, 32'h2);
    chk(irq, 1'b0);
    ctl_u.wr(`DCC_OFF_IRQ_EN, 32'h2, rs);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    ctl_u.wr(`DCC_OFF_IRQ_CLR, 32'h2, rs);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
  endtask : t_locked
  task automatic t_cal();
    cal_jumper <= 1'b1;
    repeat (4) @(posedge aclk);
    cmd(`DCC_CMD_CAL, 32'h0100_0321);
    chk(diag_mode, 1'b1);
    chk({run_option, run_routine}, 8'h21);
    cmd(`DCC_CMD_STEPQ, 32'h0);
    rdc(`DCC_OFF_STAT, 32'h40, 32'h40);
    rdc(`DCC_OFF_REPLY, 32'hC000_00FF, 32'h8000_0003);
    rdc(`DCC_OFF_STAT, 32'h40, 32'h0);
    // looping is off here, so the routine runs out and reports done
    repeat (20) @(posedge aclk);
    rdc(`DCC_OFF_IRQ_STAT, 32'h5, 32'h5);
    rdc(`DCC_OFF_STAT, 32'h3, 32'h1);
  endtask : t_cal
  task automatic t_loop();
    cmd(`DCC_CMD_LOOP, 32'h0);
    rdc(`DCC_OFF_STAT, 32'h20, 32'h20);
    cmd(`DCC_CMD_LOOPQ, 32'h0);
    rdc(`DCC_OFF_REPLY, 32'hC000_0001, 32'h4000_0001);
    cmd(`DCC_CMD_LOOP, 32'h0300_0000);
    rdc(`DCC_OFF_STAT, 32'h20, 32'h0);
    cmd(`DCC_CMD_LOOP, 32'h0100_0000);
    rdc(`DCC_OFF_STAT, 32'h20, 32'h20);
  endtask : t_loop
  // looping is on, so the routine outlives the step and query traffic
  task automatic t_go();
    cmd(`DCC_CMD_GO, 32'h0);
    chk(routine_run, 1'b1);
    rdc(`DCC_OFF_STAT, 32'h3, 32'h2);
    cmd(`DCC_CMD_STEP, 32'h0);
    rdc(`DCC_OFF_IRQ_STAT, 32'h8, 32'h8);
    cmd(`DCC_CMD_STEPQ, 32'h0);
    rdc(`DCC_OFF_REPLY, 32'hC000_00FF, 32'h8000_0004);
    cmd(`DCC_CMD_STOP, 32'h0);
    chk(routine_run, 1'b0);
    rdc(`DCC_OFF_STAT, 32'h3, 32'h1);
    coupling_btn <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(routine_run, 1'b1);
    coupling_btn <= 1'b0;
    cmd(`DCC_CMD_STOP, 32'h0);
  endtask : t_go
  task automatic t_test();
    cmd(`DCC_CMD_TEST, 32'h0100_0503);
    chk({run_option, run_routine}, 8'h35);
    cmd(`DCC_CMD_TEST, 32'h0100_0000);
    cmd(`DCC_CMD_TESTQ, 32'h0);
    rdc(`DCC_OFF_REPLY, 32'hC000_FFFF, 32'hC000_0000);
    rdc(`DCC_OFF_TRESULT, 32'hFFFF_FFFF, 32'h0);
  endtask : t_test
  task automatic t_normal();
    cmd(`DCC_CMD_NORMAL, 32'h0);
    chk(diag_mode, 1'b0);
    cmd(`DCC_CMD_NORMAL, 32'h0);
    rdc(`DCC_OFF_STAT, 32'h33, 32'h30);
  endtask : t_normal
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_locked();
    t_cal();
    t_loop();
    t_go();
    t_test();
    t_normal();
    give_verdict();
  end
endmodule : dcc_handler_tb_top
